//--- src/cpi_pkg.sv
// shared constants and types for the configuration pin interface
package cpi_pkg;
    typedef enum logic [1:0] {PASSIVE_SERIAL, FAST_PASSIVE_PARALLEL, ACTIVE_SERIAL, ACTIVE_PARALLEL} cpi_mode_t;

    typedef struct packed {
        logic [23:0] addr;
        logic        rst_n;
        logic        avd_n;
        logic        oe_n;
        logic        we_n;
    } cpi_flash_t;

    localparam cpi_flash_t FLASH_IDLE = '{addr: 24'h000000, rst_n: 1'b1, avd_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};

    // register byte addresses
    localparam logic [7:0] ADR_CTRL   = 8'h00;
    localparam logic [7:0] ADR_LEN    = 8'h04;
    localparam logic [7:0] ADR_FADDR  = 8'h08;
    localparam logic [7:0] ADR_WDATA  = 8'h0C;
    localparam logic [7:0] ADR_STATUS = 8'h10;
    localparam logic [7:0] ADR_LAST   = 8'h14;
    localparam logic [7:0] ADR_COUNT  = 8'h18;

    // control field positions
    localparam int CTL_MODE    = 0;
    localparam int CTL_APWORD  = 2;
    localparam int CTL_USER_STARTUP_CLOCK  = 3;
    localparam int CTL_SUCLK   = 4;
    localparam int CTL_CLKIO   = 5;
    localparam int CTL_GOE_EN  = 6;
    localparam int CTL_GCLR_EN = 7;
    localparam int CTL_FRST    = 8;
    localparam int CTL_CMDUSR  = 9;
    localparam int CTL_WRGO    = 10;
    localparam int CTL_W       = 11;

    localparam logic [CTL_W-1:0] CTRL_RST  = 11'h000;
    localparam logic [15:0]      LEN_RST   = 16'h0004;
    localparam logic [7:0]       AS_RD_CMD = 8'h03;
    localparam int               OPT_INIT  = 0;
    localparam int               OPT_TERM  = 1;
    localparam logic [7:0]       INIT_TICKS = 8'h10;

    localparam int CLK_PERIOD_NS = 100;
    localparam int CFG_HALF_NS   = 400;
    localparam int FWR_PULSE_NS  = 200;
    localparam logic [3:0] CFG_HALF_CYC = 4'((CFG_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] FWR_CYC      = 4'((FWR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage : cpi_pkg

//--- src/cpi_sync.sv
// two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module cpi_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_reg;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    meta_reg[i] <= 1'b0;
                    q_out[i]    <= 1'b0;
                end else begin
                    meta_reg[i] <= d_in[i];
                    q_out[i]    <= meta_reg[i];
                end
            end
        end
    endgenerate
endmodule : cpi_sync

//--- src/cpi_loader.sv
// configuration pin interface: loader, flash strobes, init and wishbone registers
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - passive modes: sample data on host clock rise
// - active modes: device drives config clock
// - active modes: park clock after configuration
// - configured device ignores config clock toggling
// - serial modes: one bit per clock on data0
// - active serial: send read command stream
// - active parallel: byte or word per clock
// - active parallel: drive 24-bit word address
// - flash reset driven low to reset flash
// - address valid low during flash access
// - read drive low during flash read
// - write enable low during flash write
// - unused data lines tri-stated during configuration
// - pins stay dedicated, user controlled afterwards
// - disabled optional pins tri-stated during configuration
// - startup clock times initialization when enabled
// - init indicator: float, low, then release
// - optional gating of release on termination
// - global output enable low tri-states pins
// - global clear low clears device registers
// - active serial clock from startup clock option
// - reconfig request low resets and tri-states
// - load complete low until data received
module cpi_loader (
    input  wire logic               ref_clk_in,
    input  wire logic               rst_n_in,
    input  wire logic               wb_cyc_in,
    input  wire logic               wb_stb_in,
    input  wire logic               wb_we_in,
    input  wire logic [7:0]         wb_adr_in,
    input  wire logic [3:0]         wb_sel_in,
    input  wire logic [31:0]        wb_dat_in,
    output logic      [31:0]        wb_dat_out,
    output logic                    wb_ack_out,
    input  wire logic               config_clock_in,
    output logic                    config_clock_out,
    output logic                    config_clock_oe_out,
    input  wire logic [15:0]        config_data_in,
    output logic      [15:0]        config_data_out,
    output logic                    config_data_oe_out,
    output logic                    serial_cmd_out,
    output cpi_pkg::cpi_flash_t     flash_out,
    input  wire logic               user_startup_clock_in,
    input  wire logic               termination_cal_complete_in,
    input  wire logic               global_output_enable_in,
    input  wire logic               global_clear_n_in,
    input  wire logic               reconfig_request_n_in,
    input  wire logic               load_complete_in,
    output logic                    load_complete_out,
    output logic                    load_complete_oe_out,
    output logic                    init_complete_out,
    output logic                    init_complete_oe_out
);
    typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_LOAD, ST_WAITD, ST_INIT, ST_USER} cpi_state_t;

    //////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [23:0] s_bus;
    logic [15:0] s_data;
    logic        s_clk, s_uclk, s_term, s_goe, s_gclr_n, s_reconf, s_reconf_req, s_ldone;
    cpi_sync #(.W(24)) u_sync (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .d_in       ({config_clock_in, user_startup_clock_in, termination_cal_complete_in,
                      global_output_enable_in, global_clear_n_in, ~reconfig_request_n_in,
                      load_complete_in, config_data_in, 1'b0}),
        .q_out      (s_bus)
    );
    assign {s_clk, s_uclk, s_term, s_goe, s_gclr_n, s_reconf_req, s_ldone, s_data} = s_bus[23:1];
    assign s_reconf = ~s_reconf_req; // stored inverted so the sync reset value reads idle: no false start

    logic s_clk_d_reg, s_uclk_d_reg, s_reconf_d_reg;
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_clk_d_reg    <= 1'b0;
            s_uclk_d_reg   <= 1'b0;
            s_reconf_d_reg <= 1'b1;
        end else begin
            s_clk_d_reg    <= s_clk;
            s_uclk_d_reg   <= s_uclk;
            s_reconf_d_reg <= s_reconf;
        end
    end
    logic clk_rise, uclk_rise, reconf_rise;
    assign clk_rise    = s_clk & ~s_clk_d_reg;
    assign uclk_rise   = s_uclk & ~s_uclk_d_reg;
    assign reconf_rise = s_reconf & ~s_reconf_d_reg;

    //////////////////////////////////////////////////////////////////////////
    // registers
    logic [cpi_pkg::CTL_W-1:0] ctrl_reg;
    logic [15:0]               len_reg, wdata_reg, last_reg, wcnt_reg;
    logic [23:0]               faddr_reg;
    cpi_state_t                st_reg;
    cpi_pkg::cpi_mode_t        mode_reg;
    logic [1:0]                opt_reg;
    logic                      wr_busy_reg;

    logic hit_wr, goe_off;
    assign hit_wr  = wb_cyc_in & wb_stb_in & wb_we_in & wb_ack_out; // write lands on the edge that samples ack
    assign goe_off = ctrl_reg[cpi_pkg::CTL_GOE_EN] & ~s_goe;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) old[8*b +: 8] = nw[8*b +: 8];
        end
        return old;
    endfunction : merge

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_reg  <= cpi_pkg::CTRL_RST;
            len_reg   <= cpi_pkg::LEN_RST;
            faddr_reg <= 24'h000000;
            wdata_reg <= 16'h0000;
        end else begin
            if (wr_busy_reg) begin
                ctrl_reg[cpi_pkg::CTL_WRGO] <= 1'b0;
            end
            if (hit_wr) begin
                unique case (wb_adr_in)
                    cpi_pkg::ADR_CTRL:  ctrl_reg  <= cpi_pkg::CTL_W'(merge({21'h0, ctrl_reg}, wb_dat_in, wb_sel_in));
                    cpi_pkg::ADR_LEN:   len_reg   <= 16'(merge({16'h0, len_reg}, wb_dat_in, wb_sel_in));
                    cpi_pkg::ADR_FADDR: faddr_reg <= 24'(merge({8'h0, faddr_reg}, wb_dat_in, wb_sel_in));
                    cpi_pkg::ADR_WDATA: wdata_reg <= 16'(merge({16'h0, wdata_reg}, wb_dat_in, wb_sel_in));
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h00000000;
        end else begin
            wb_ack_out <= wb_cyc_in & wb_stb_in & ~wb_ack_out;
            unique case (wb_adr_in)
                cpi_pkg::ADR_CTRL:   wb_dat_out <= {21'h0, ctrl_reg};
                cpi_pkg::ADR_LEN:    wb_dat_out <= {16'h0, len_reg};
                cpi_pkg::ADR_FADDR:  wb_dat_out <= {8'h0, faddr_reg};
                cpi_pkg::ADR_WDATA:  wb_dat_out <= {16'h0, wdata_reg};
                cpi_pkg::ADR_STATUS: wb_dat_out <= {23'h0, wr_busy_reg, opt_reg, s_term, mode_reg, st_reg};
                cpi_pkg::ADR_LAST:   wb_dat_out <= {s_data, last_reg};
                cpi_pkg::ADR_COUNT:  wb_dat_out <= {16'h0, wcnt_reg};
                default:             wb_dat_out <= 32'h00000000;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // active-mode clock generation
    logic [3:0] div_reg;
    logic       clk_reg, a_rise, a_fall, active, loading, tick;
    assign active  = (mode_reg == cpi_pkg::ACTIVE_SERIAL) | (mode_reg == cpi_pkg::ACTIVE_PARALLEL);
    assign loading = (st_reg == ST_CMD) | (st_reg == ST_LOAD);
    // startup clock as source only in active serial; otherwise the local divider
    assign tick = (ctrl_reg[cpi_pkg::CTL_USER_STARTUP_CLOCK] && mode_reg == cpi_pkg::ACTIVE_SERIAL) ? uclk_rise
                : (div_reg == cpi_pkg::CFG_HALF_CYC - 4'h1);
    assign a_rise = active & loading & tick & ~clk_reg;
    assign a_fall = active & loading & tick & clk_reg;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_reg <= 4'h0;
            clk_reg <= 1'b0;
        end else if (!(active && loading)) begin
            div_reg <= 4'h0;
            clk_reg <= 1'b0;
        end else begin
            div_reg <= tick ? 4'h0 : div_reg + 4'h1;
            if (tick) clk_reg <= ~clk_reg;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // load sequencer
    logic [15:0] sr_reg;
    logic [4:0]  bit_reg, step;
    logic [5:0]  cmd_cnt_reg;
    logic [31:0] cmd_sr_reg;
    logic [7:0]  init_cnt_reg;
    logic        samp;
    assign samp = (st_reg == ST_LOAD) & (active ? a_rise : clk_rise);
    always_comb begin
        unique case (mode_reg)
            cpi_pkg::FAST_PASSIVE_PARALLEL: step = 5'd8;
            cpi_pkg::ACTIVE_PARALLEL:       step = ctrl_reg[cpi_pkg::CTL_APWORD] ? 5'd16 : 5'd8;
            default:                        step = 5'd1;
        endcase
    end
    logic [15:0] sr_next;
    assign sr_next = (step == 5'd16) ? s_data
                   : (step == 5'd8)  ? {sr_reg[7:0], s_data[7:0]}
                   : {sr_reg[14:0], s_data[0]};

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg       <= ST_IDLE;
            mode_reg     <= cpi_pkg::PASSIVE_SERIAL;
            sr_reg       <= 16'h0000;
            bit_reg      <= 5'd0;
            wcnt_reg     <= 16'h0000;
            opt_reg      <= 2'b00;
            cmd_cnt_reg  <= 6'd0;
            cmd_sr_reg   <= 32'h00000000;
            init_cnt_reg <= 8'h00;
        end else if (!s_reconf) begin
            st_reg <= ST_IDLE;
        end else begin
            unique case (st_reg)
                ST_IDLE: if (reconf_rise) begin
                    mode_reg    <= cpi_pkg::cpi_mode_t'(ctrl_reg[cpi_pkg::CTL_MODE +: 2]);
                    st_reg      <= (ctrl_reg[cpi_pkg::CTL_MODE +: 2] == 2'(cpi_pkg::ACTIVE_SERIAL)) ? ST_CMD : ST_LOAD;
                    bit_reg     <= 5'd0;
                    wcnt_reg    <= 16'h0000;
                    opt_reg     <= 2'b00;
                    cmd_cnt_reg <= 6'd0;
                    cmd_sr_reg  <= {cpi_pkg::AS_RD_CMD, faddr_reg};
                end
                ST_CMD: if (a_fall) begin
                    cmd_sr_reg  <= {cmd_sr_reg[30:0], 1'b0};
                    cmd_cnt_reg <= cmd_cnt_reg + 6'd1;
                    if (cmd_cnt_reg == 6'd31) st_reg <= ST_LOAD;
                end
                ST_LOAD: if (samp) begin
                    sr_reg  <= sr_next;
                    bit_reg <= (bit_reg + step == 5'd16) ? 5'd0 : bit_reg + step;
                    if (bit_reg + step == 5'd16) begin
                        wcnt_reg <= wcnt_reg + 16'h0001;
                        if (wcnt_reg == 16'h0000) opt_reg <= sr_next[1:0];
                        if (wcnt_reg + 16'h0001 == len_reg) st_reg <= ST_WAITD;
                    end
                end
                ST_WAITD: if (s_ldone) begin
                    st_reg       <= ST_INIT;
                    init_cnt_reg <= 8'h00;
                end
                ST_INIT: begin
                    if (init_cnt_reg != cpi_pkg::INIT_TICKS) begin
                        if (!ctrl_reg[cpi_pkg::CTL_SUCLK] || uclk_rise) init_cnt_reg <= init_cnt_reg + 8'h01;
                    end else if (!opt_reg[cpi_pkg::OPT_TERM] || s_term) begin
                        st_reg <= ST_USER;
                    end
                end
                ST_USER: ;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // flash write helper, only in user mode
    logic [3:0] wr_cnt_reg;
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_busy_reg <= 1'b0;
            wr_cnt_reg  <= 4'h0;
        end else if (!wr_busy_reg) begin
            wr_busy_reg <= ctrl_reg[cpi_pkg::CTL_WRGO] & (st_reg == ST_USER);
            wr_cnt_reg  <= 4'h0;
        end else begin
            wr_cnt_reg <= wr_cnt_reg + 4'h1;
            if (wr_cnt_reg == cpi_pkg::FWR_CYC) wr_busy_reg <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // pin drivers
    logic [23:0] fa_reg;
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fa_reg    <= 24'h000000;
            flash_out <= cpi_pkg::FLASH_IDLE;
        end else begin
            if (st_reg == ST_IDLE) fa_reg <= faddr_reg;
            else if (samp && mode_reg == cpi_pkg::ACTIVE_PARALLEL) fa_reg <= fa_reg + 24'h000001;
            flash_out <= cpi_pkg::FLASH_IDLE;
            flash_out.rst_n <= ~(ctrl_reg[cpi_pkg::CTL_FRST]
                               | (!s_reconf && mode_reg == cpi_pkg::ACTIVE_PARALLEL));
            if (st_reg == ST_LOAD && mode_reg == cpi_pkg::ACTIVE_PARALLEL) begin
                flash_out.addr  <= fa_reg;
                flash_out.avd_n <= 1'b0;
                flash_out.oe_n  <= 1'b0;
            end else if (wr_busy_reg) begin
                flash_out.addr  <= faddr_reg;
                flash_out.avd_n <= 1'b0;
                flash_out.we_n  <= 1'b0;
            end
        end
    end

    // data lines are only driven by a user-mode flash write, never while loading
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            config_data_out    <= 16'h0000;
            config_data_oe_out <= 1'b0;
            serial_cmd_out     <= 1'b0;
            last_reg           <= 16'h0000;
        end else begin
            config_data_out    <= wdata_reg;
            config_data_oe_out <= wr_busy_reg & s_reconf & ~goe_off & (st_reg == ST_USER);
            serial_cmd_out     <= (st_reg == ST_USER) ? ctrl_reg[cpi_pkg::CTL_CMDUSR] : cmd_sr_reg[31];
            if (ctrl_reg[cpi_pkg::CTL_GCLR_EN] && !s_gclr_n) last_reg <= 16'h0000;
            else if (samp && bit_reg + step == 5'd16) last_reg <= sr_next;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            config_clock_out    <= 1'b0;
            config_clock_oe_out <= 1'b0;
        end else begin
            config_clock_out    <= loading & clk_reg;
            config_clock_oe_out <= active & s_reconf & ~goe_off & (st_reg != ST_IDLE)
                                 & ~(st_reg == ST_USER && ctrl_reg[cpi_pkg::CTL_CLKIO]);
        end
    end

    // open-drain indicators: out stays low, oe pulls the wire down
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            load_complete_out    <= 1'b0;
            load_complete_oe_out <= 1'b1;
            init_complete_out    <= 1'b0;
            init_complete_oe_out <= 1'b0;
        end else begin
            load_complete_out    <= 1'b0;
            load_complete_oe_out <= (st_reg == ST_IDLE) | loading;
            init_complete_out    <= 1'b0;
            init_complete_oe_out <= s_reconf & opt_reg[cpi_pkg::OPT_INIT]
                                  & (st_reg inside {ST_LOAD, ST_WAITD, ST_INIT});
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // checks
    a_passive_clk_in: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        !active |=> !config_clock_oe_out) else $error("clock driven in passive mode");
    a_user_clk_park: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (st_reg == ST_USER) ##1 (st_reg == ST_USER) |-> !config_clock_out) else $error("clock not parked");
    a_user_ignores_clk: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (st_reg == ST_USER && s_reconf) |=> (st_reg == ST_USER)) else $error("user mode left");
    a_load_held_low: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (st_reg == ST_LOAD) |=> load_complete_oe_out) else $error("load complete released early");
    a_data_tristate: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (st_reg != ST_USER) |=> !config_data_oe_out) else $error("data driven during load");
    a_reconfig_tri: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        !s_reconf |=> !config_clock_oe_out && !config_data_oe_out && (st_reg == ST_IDLE))
        else $error("not tri-stated on reconfig");
    a_goe_tristate: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        goe_off |=> !config_clock_oe_out && !config_data_oe_out) else $error("pins driven under global oe");
    a_term_gate: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (st_reg == ST_INIT && opt_reg[cpi_pkg::OPT_TERM] && !s_term) |=> (st_reg != ST_USER))
        else $error("init released before termination");
    a_ap_strobes: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (st_reg == ST_LOAD && mode_reg == cpi_pkg::ACTIVE_PARALLEL && s_reconf)
        |=> !flash_out.oe_n && !flash_out.avd_n) else $error("flash read strobes missing");

    c_as_user: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        st_reg == ST_USER && mode_reg == cpi_pkg::ACTIVE_SERIAL);
    c_ap_user: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        st_reg == ST_USER && mode_reg == cpi_pkg::ACTIVE_PARALLEL);
    c_ps_user: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        st_reg == ST_USER && mode_reg == cpi_pkg::PASSIVE_SERIAL);
endmodule : cpi_loader

//--- test/cpi_host_model.sv
// passive serial control host driving the configuration clock and data0
`timescale 1ns/1ps
module cpi_host_model (
    input  wire logic        start_in,
    input  wire logic [15:0] word_in,
    output logic             clk_out,
    output logic             data_out,
    output logic             busy_out
);
    // one process owns every output; data set 400 ns ahead of each rise, so the device sees it settled
    initial begin
        clk_out  = 1'b0;
        data_out = 1'b1;
        busy_out = 1'b0;
        forever begin
            @(posedge start_in);
            busy_out = 1'b1;
            for (int i = 15; i >= 0; i--) begin
                data_out = word_in[i];
                #400 clk_out = 1'b1;
                #400 clk_out = 1'b0;
            end
            // clock parks low between frames; data no longer holds its value
            data_out = ~data_out;
            busy_out = 1'b0;
        end
    end
endmodule : cpi_host_model

//--- test/tb.sv
// self-checking bench for the configuration loader
`timescale 1ns/1ps
module tb;
    logic ref_clk_in, rst_n_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out, config_clock_in, config_clock_out;
    logic [7:0] wb_adr_in;
    logic [3:0] wb_sel_in;
    logic [31:0] wb_dat_in, wb_dat_out, seed;
    logic [15:0] config_data_in, config_data_out, host_word;
    logic config_clock_oe_out, config_data_oe_out, serial_cmd_out, user_startup_clock_in, host_d, host_busy;
    logic termination_cal_complete_in, global_output_enable_in, global_clear_n_in, reconfig_request_n_in;
    logic load_complete_in, load_complete_out, load_complete_oe_out, init_complete_out, init_complete_oe_out;
    logic host_start;
    cpi_pkg::cpi_flash_t flash_out;
    logic [63:0] notes[$];
    int errors, compares, n;
    assign config_data_in = {15'h0000, host_d};
    // open-drain wire with pull-up
    assign load_complete_in = ~load_complete_oe_out;
    cpi_loader dut (.*);
    cpi_host_model host (.start_in(host_start), .word_in(host_word), .clk_out(config_clock_in),
                         .data_out(host_d), .busy_out(host_busy));
    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input logic [31:0] m);
        compares++;
        if ((seen & m) !== (exp & m)) begin
            errors++;
            $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    // classic cycle; a read leaves its expectation for the monitor
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in  <= we;
        wb_adr_in <= a;
        wb_dat_in <= d;
        wb_sel_in <= 4'hF;
        if (!we) notes.push_back({m, d});
        // no answer time assumed: only the watchdog ends a missing ack
        do @(posedge ref_clk_in); while (wb_ack_out !== 1'b1);
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        @(posedge ref_clk_in);
    endtask : wb
    always @(posedge ref_clk_in) begin
        if (wb_ack_out === 1'b1 && wb_we_in === 1'b0 && notes.size() > 0) begin
            check(wb_dat_out, notes[0][31:0], notes[0][63:32]);
            void'(notes.pop_front());
        end
    end
    task automatic results;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results
    initial begin
        #4000000;
        errors++;
        results();
    end
    initial begin
        {wb_cyc_in, wb_stb_in, wb_we_in, user_startup_clock_in, termination_cal_complete_in, host_start} = '0;
        {wb_adr_in, wb_sel_in, wb_dat_in} = '0;
        {global_output_enable_in, global_clear_n_in, reconfig_request_n_in} = 3'b111;
        rst_n_in = 1'b0;
        seed = 32'h6235;
        host_word = 16'h0000;
        repeat (6) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        wb(1'b0, cpi_pkg::ADR_LEN, 32'(cpi_pkg::LEN_RST), 32'hFFFFFFFF);
        wb(1'b0, cpi_pkg::ADR_CTRL, 32'h00000000, 32'hFFFFFFFF);
        wb(1'b0, 8'h1C, 32'h00000000, 32'hFFFFFFFF);
        wb(1'b1, cpi_pkg::ADR_STATUS, 32'hFFFFFFFF, 32'h0);
        wb(1'b0, cpi_pkg::ADR_STATUS, 32'h00000000, 32'h0000001F);
        $display("test registers done");
        host_word = 16'($random(seed)) | 16'h0003;
        wb(1'b1, cpi_pkg::ADR_LEN, 32'h00000001, 32'h0);
        wb(1'b1, cpi_pkg::ADR_CTRL, 32'h000000C0, 32'h0);
        reconfig_request_n_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        check(32'(load_complete_oe_out), 32'h1, 32'h1);
        reconfig_request_n_in <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        host_start <= 1'b1;
        wait (host_busy);
        host_start <= 1'b0;
        wait (!host_busy);
        for (n = 0; n < 40 && load_complete_oe_out !== 1'b0; n++) @(posedge ref_clk_in);
        check(32'(load_complete_oe_out), 32'h0, 32'h1);
        check(32'(init_complete_oe_out), 32'h1, 32'h1);
        repeat (60) @(posedge ref_clk_in);
        wb(1'b0, cpi_pkg::ADR_STATUS, 32'h00000004, 32'h00000007);
        check(32'(init_complete_oe_out), 32'h1, 32'h1);
        termination_cal_complete_in <= 1'b1;
        for (n = 0; n < 80 && init_complete_oe_out !== 1'b0; n++) @(posedge ref_clk_in);
        check(32'(init_complete_oe_out), 32'h0, 32'h1);
        wb(1'b0, cpi_pkg::ADR_STATUS, 32'h000000E5, 32'h000001FF);
        wb(1'b0, cpi_pkg::ADR_LAST, 32'(host_word), 32'h0000FFFF);
        wb(1'b0, cpi_pkg::ADR_COUNT, 32'h00000001, 32'hFFFFFFFF);
        $display("test passive load done");
        host_word <= ~host_word;
        host_start <= 1'b1;
        wait (host_busy);
        host_start <= 1'b0;
        wait (!host_busy);
        repeat (8) @(posedge ref_clk_in);
        wb(1'b0, cpi_pkg::ADR_COUNT, 32'h00000001, 32'hFFFFFFFF);
        wb(1'b0, cpi_pkg::ADR_LAST, 32'(~host_word), 32'h0000FFFF);
        $display("test user mode clock done");
        global_clear_n_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        wb(1'b0, cpi_pkg::ADR_LAST, 32'h00000000, 32'h0000FFFF);
        global_clear_n_in <= 1'b1;
        $display("test global clear done");
        wb(1'b1, cpi_pkg::ADR_LEN, 32'h00000002, 32'h0);
        wb(1'b1, cpi_pkg::ADR_FADDR, 32'h00000010, 32'h0);
        wb(1'b1, cpi_pkg::ADR_CTRL, 32'h00000047, 32'h0);
        reconfig_request_n_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        reconfig_request_n_in <= 1'b1;
        repeat (6) @(posedge ref_clk_in);
        check(32'({flash_out.avd_n, flash_out.oe_n, config_clock_oe_out}), 32'h1, 32'h7);
        check(32'(flash_out.addr), 32'h00000010, 32'h00FFFFFF);
        repeat (60) @(posedge ref_clk_in);
        wb(1'b0, cpi_pkg::ADR_STATUS, 32'h0000001D, 32'h0000001F);
        wb(1'b0, cpi_pkg::ADR_COUNT, 32'h00000002, 32'hFFFFFFFF);
        wb(1'b0, cpi_pkg::ADR_LAST, 32'(host_d), 32'h0000FFFF);
        check(32'({config_clock_oe_out, config_clock_out}), 32'h2, 32'h3);
        global_output_enable_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        check(32'(config_clock_oe_out), 32'h0, 32'h1);
        global_output_enable_in <= 1'b1;
        reconfig_request_n_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        check(32'(flash_out.rst_n), 32'h0, 32'h1);
        check(32'(config_clock_oe_out), 32'h0, 32'h1);
        $display("test active parallel done");
        results();
    end
endmodule : tb
